// ===== sim/bdx_exec_asserts.sv
`timescale 1ns/1ps
module bdx_exec_asserts #(parameter REG_W = 32, parameter TIMEOUT = 512) (
    input wire CLK_SYS,
    input wire RST,
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    input wire [31:0] AVS_READDATA,
    input wire AVS_WAITREQUEST,
    input wire IRQ,
    input wire CPU_HALTED,
    input wire CPU_RESUME,
    input wire CPU_FLUSH,
    input wire [3:0] REG_NUM,
    input wire REG_RD,
    input wire [REG_W-1:0] REG_DATA,
    input wire MEM_RD,
    input wire [23:0] MEM_ADDR,
    input wire [1:0] MEM_SIZE,
    input wire MEM_DONE,
    input wire [31:0] MEM_DATA,
    input wire TB_RD,
    input wire TB_HALF,
    input wire TB_DONE,
    input wire [31:0] TB_DATA,
    input wire ACK_PULSE,
    input wire DLY_DONE
);
    reg acken_ff;
    reg [7:0] cmd_ff;
    wire tb_lo_done;
    assign tb_lo_done = TB_RD && TB_DONE && !TB_HALF;
    // shadows of ctrl and last command, seen from the bus side only
    always @(posedge CLK_SYS) begin
        if (RST) begin
            acken_ff <= 1'b0;
            cmd_ff <= 8'h00;
        end else if (AVS_WRITE && AVS_ADDRESS == 5'h00) acken_ff <= AVS_WRITEDATA[0];
        else if (AVS_WRITE && AVS_ADDRESS == 5'h08) cmd_ff <= AVS_WRITEDATA[7:0];
    end
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    AST_FLUSH: assert property (CPU_RESUME |-> (CPU_FLUSH || $past(CPU_FLUSH)) or (##1 CPU_FLUSH))
        else $error("resume without pipeline flush");
    AST_ACK_ONE: assert property (ACK_PULSE |=> !ACK_PULSE)
        else $error("ack longer than one cycle");
    AST_ACK_EN: assert property (ACK_PULSE |-> acken_ff)
        else $error("ack while handshake off");
    AST_ALIGN: assert property (MEM_RD && MEM_SIZE == 2'b10 |-> MEM_ADDR[1:0] == 2'b00)
        else $error("long access not aligned");
    AST_MEM_HOLD: assert property (MEM_RD && !MEM_DONE |=> !MEM_RD || $stable(MEM_ADDR))
        else $error("memory address moved mid access");
    AST_MEM_ACK: assert property (MEM_RD && MEM_DONE && acken_ff && !cmd_ff[0] |=> ACK_PULSE)
        else $error("no ack after memory access");
    AST_WS_DLY: assert property (MEM_RD && MEM_DONE && cmd_ff[0] |=> !ACK_PULSE ##[13:17] DLY_DONE)
        else $error("status read lacks fixed delay");
    AST_REG_SEL: assert property (REG_RD |-> REG_NUM == cmd_ff[3:0] && cmd_ff[7:4] == 4'h6)
        else $error("register number not from command");
    // the high half may only rise one gap after the low half completed
    AST_TB_FIRST: assert property ($rose(TB_RD) |-> !TB_HALF || $past(tb_lo_done, 17))
        else $error("trace read not starting low half");
    AST_TB_ACK: assert property (TB_RD && TB_DONE && acken_ff |=> ACK_PULSE)
        else $error("no ack per trace longword");
    COV_ACK: cover property (ACK_PULSE);
    COV_DLY: cover property (DLY_DONE);
    COV_TB2: cover property (TB_RD && TB_HALF && TB_DONE);
    COV_RES: cover property (CPU_RESUME);
endmodule // bdx_exec_asserts

// ===== sim/bdx_tgt.sv
`timescale 1ns/1ps
module bdx_tgt (
    input wire CLK_SYS,
    input wire RST,
    input wire halt_req,
    input wire tb_stall,
    input wire CPU_RESUME,
    input wire MEM_RD,
    input wire [23:0] MEM_ADDR,
    input wire [1:0] MEM_SIZE,
    input wire TB_RD,
    input wire TB_HALF,
    output reg CPU_HALTED,
    output wire [15:0] REG_DATA,
    output reg MEM_DONE,
    output wire [31:0] MEM_DATA,
    output reg TB_DONE,
    output wire [31:0] TB_DATA,
    output reg [23:0] lst_addr,
    output reg [1:0] lst_size
);
    reg [1:0] mcnt_ff, tcnt_ff;
    assign REG_DATA = 16'hc3a5;
    // data not valid outside done shows the inverse, never a stale match
    assign MEM_DATA = MEM_DONE ? {8'h5a, MEM_ADDR} : ~{8'h5a, MEM_ADDR};
    assign TB_DATA = (TB_HALF ? 32'h89abcdef : 32'h01234567) ^ {32{!TB_DONE}};
    always @(posedge CLK_SYS) begin
        if (RST) CPU_HALTED <= 1'b1;
        else if (CPU_RESUME) CPU_HALTED <= 1'b0;
        else if (halt_req) CPU_HALTED <= 1'b1;
        mcnt_ff <= (MEM_RD && !MEM_DONE && !RST) ? mcnt_ff + 2'd1 : 2'd0;
        MEM_DONE <= MEM_RD && !MEM_DONE && !RST && mcnt_ff == 2'd2;
        tcnt_ff <= (TB_RD && !TB_DONE && !RST) ? tcnt_ff + 2'd1 : 2'd0;
        // a stalled high half never answers, to reach the response timeout
        TB_DONE <= TB_RD && !TB_DONE && !RST && tcnt_ff == 2'd1 && !(tb_stall && TB_HALF);
        if (MEM_RD) lst_addr <= MEM_ADDR;
        if (MEM_RD) lst_size <= MEM_SIZE;
    end
endmodule // bdx_tgt

// ===== sim/testbench.sv
`timescale 1ns/1ps
`include "bdx_defs.vh"
module testbench;
    logic CLK_SYS = 0, RST = 1, AVS_READ = 0, AVS_WRITE = 0, halt_req = 0, tb_stall = 0;
    logic [4:0] AVS_ADDRESS = 5'h00;
    logic [31:0] AVS_WRITEDATA = 32'h0, v;
    wire [31:0] AVS_READDATA, MEM_DATA, TB_DATA;
    wire [23:0] MEM_ADDR, lst_addr;
    wire [15:0] REG_DATA;
    wire [3:0] REG_NUM;
    wire [1:0] MEM_SIZE, lst_size;
    wire AVS_WAITREQUEST, IRQ, CPU_HALTED, CPU_RESUME, CPU_FLUSH, REG_RD, MEM_RD, MEM_DONE;
    wire TB_RD, TB_HALF, TB_DONE, ACK_PULSE, DLY_DONE;
    int n_errors = 0, num_checks = 0, acks = 0, rsm = 0, rrd = 0, cyc = 0, a0;
    logic [7:0] codes [3] = '{8'h30, 8'h34, 8'h38};
    bdx_exec #(.REG_W(16), .TIMEOUT(20)) u_bdx_exec (.CLK_SYS(CLK_SYS), .RST(RST),
        .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
        .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
        .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .CPU_HALTED(CPU_HALTED),
        .CPU_RESUME(CPU_RESUME), .CPU_FLUSH(CPU_FLUSH), .REG_NUM(REG_NUM), .REG_RD(REG_RD),
        .REG_DATA(REG_DATA), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_SIZE(MEM_SIZE),
        .MEM_DONE(MEM_DONE), .MEM_DATA(MEM_DATA), .TB_RD(TB_RD), .TB_HALF(TB_HALF),
        .TB_DONE(TB_DONE), .TB_DATA(TB_DATA), .ACK_PULSE(ACK_PULSE), .DLY_DONE(DLY_DONE));
    bdx_tgt u_bdx_tgt (.CLK_SYS(CLK_SYS), .RST(RST), .halt_req(halt_req), .tb_stall(tb_stall),
        .CPU_RESUME(CPU_RESUME), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_SIZE(MEM_SIZE),
        .TB_RD(TB_RD), .TB_HALF(TB_HALF), .CPU_HALTED(CPU_HALTED), .REG_DATA(REG_DATA),
        .MEM_DONE(MEM_DONE), .MEM_DATA(MEM_DATA), .TB_DONE(TB_DONE), .TB_DATA(TB_DATA),
        .lst_addr(lst_addr), .lst_size(lst_size));
    initial forever #4 CLK_SYS = ~CLK_SYS;
    task close_out;
        if (n_errors == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge CLK_SYS) begin
        acks <= acks + ACK_PULSE;
        rsm <= rsm + CPU_RESUME;
        rrd <= rrd + REG_RD;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            close_out;
        end
    end
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [4:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        AVS_WRITE <= 1'b1;
        @(posedge CLK_SYS);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
        AVS_WRITE <= 1'b0;
    endtask
    task rd(input logic [4:0] a, output logic [31:0] d);
        @(posedge CLK_SYS);
        AVS_ADDRESS <= a;
        AVS_READ <= 1'b1;
        @(posedge CLK_SYS);
        while (AVS_WAITREQUEST !== 1'b0) @(posedge CLK_SYS);
        d = AVS_READDATA;
        AVS_READ <= 1'b0;
    endtask
    task cmd(input logic [7:0] c, input logic [23:0] a);
        wr(`BDX_REG_CMD, {a, c});
        rd(`BDX_REG_STAT, v);
        repeat (100) if (v[`BDX_ST_BUSY] !== 1'b0) rd(`BDX_REG_STAT, v);
    endtask
    task hlt;
        @(posedge CLK_SYS);
        halt_req <= 1'b1;
        @(posedge CLK_SYS);
        halt_req <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
    endtask
    initial begin
        repeat (4) @(posedge CLK_SYS);
        RST <= 1'b0;
        repeat (4) @(posedge CLK_SYS);
        cmd(`BDX_CMD_NOP, 24'h0);
        chk("stat_nop", v[6:4], 3'b100);
        wr(`BDX_REG_CTRL, 32'h1);
        cmd(`BDX_CMD_RDREG_BASE | 8'h03, 24'h0);
        rd(`BDX_REG_RDATA, v);
        chk("reg_data", v, 32'h0000c3a5);
        chk("reg_ack", acks, 1);
        foreach (codes[i]) begin
            cmd(codes[i], 24'h123457);
            chk("mem_addr", lst_addr, codes[i] == 8'h38 ? 24'h123454 : 24'h123457);
            chk("mem_size", lst_size, codes[i][3:2]);
        end
        rd(`BDX_REG_RDATA, v);
        chk("mem_long", v, 32'h5a123454);
        cmd(`BDX_CMD_RDMEM_LS, 24'h000102);
        rd(`BDX_REG_RDATA2, v);
        chk("ws_status", v[6:4], 3'b110);
        a0 = acks;
        cmd(`BDX_CMD_TRACE, 24'h0);
        rd(`BDX_REG_RDATA, v);
        chk("tb_low", v, 32'h01234567);
        rd(`BDX_REG_RDATA2, v);
        chk("tb_high", v, 32'h89abcdef);
        chk("tb_acks", acks - a0, 2);
        a0 = acks;
        wr(`BDX_REG_CMD, {24'h0, `BDX_CMD_GO_UNTIL});
        repeat (60) @(posedge CLK_SYS);
        rd(`BDX_REG_STAT, v);
        chk("gu_wait", v[3:2], 2'b10);
        chk("gu_noack", acks, a0);
        hlt;
        rd(`BDX_REG_IRQ, v);
        chk("irq_halt", v[2], 1'b1);
        cmd(`BDX_CMD_NOP, 24'h0);
        chk("gu_ack", acks, a0 + 1);
        chk("gu_resume", rsm, 1);
        wr(`BDX_REG_CMD, {24'h0, `BDX_CMD_GO_UNTIL});
        repeat (10) @(posedge CLK_SYS);
        wr(`BDX_REG_CTRL, 32'h3);
        cmd(`BDX_CMD_NOP, 24'h0);
        chk("sync_idle", v[3], 1'b0);
        wr(`BDX_REG_CTRL, 32'h0);
        rd(`BDX_REG_IRQ, v);
        cmd(`BDX_CMD_GO_UNTIL, 24'h0);
        chk("gu_ill", v[4], 1'b1);
        chk("gu_ill_run", rsm, 2);
        chk("irq_masked", IRQ, 1'b0);
        wr(`BDX_REG_MASK, 32'h2);
        repeat (2) @(posedge CLK_SYS);
        chk("irq_on", IRQ, 1'b1);
        rd(`BDX_REG_IRQ, v);
        chk("irq_ill", v[1], 1'b1);
        repeat (2) @(posedge CLK_SYS);
        chk("irq_clr", IRQ, 1'b0);
        cmd(`BDX_CMD_RDREG_BASE | 8'h03, 24'h0);
        chk("reg_no_access", rrd, 1);
        hlt;
        a0 = acks;
        cmd(`BDX_CMD_GO_UNTIL, 24'h0);
        chk("go_plain", rsm, 3);
        chk("go_noack", acks, a0);
        a0 = acks;
        cmd(`BDX_CMD_TRACE, 24'h0);
        rd(`BDX_REG_RDATA2, v);
        chk("tb_gap_high", v, 32'h89abcdef);
        chk("tb_gap_noack", acks, a0);
        tb_stall <= 1'b1;
        wr(`BDX_REG_CTRL, 32'h1);
        a0 = acks;
        cmd(`BDX_CMD_TRACE, 24'h0);
        chk("tb_timeout", v[2], 1'b1);
        chk("tb_to_acks", acks, a0 + 1);
        close_out;
    end
endmodule // testbench
bind bdx_exec bdx_exec_asserts #(.REG_W(REG_W), .TIMEOUT(TIMEOUT)) u_bdx_exec_asserts (
    .CLK_SYS(CLK_SYS), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ), .CPU_HALTED(CPU_HALTED),
    .CPU_RESUME(CPU_RESUME), .CPU_FLUSH(CPU_FLUSH), .REG_NUM(REG_NUM), .REG_RD(REG_RD),
    .REG_DATA(REG_DATA), .MEM_RD(MEM_RD), .MEM_ADDR(MEM_ADDR), .MEM_SIZE(MEM_SIZE),
    .MEM_DONE(MEM_DONE), .MEM_DATA(MEM_DATA), .TB_RD(TB_RD), .TB_HALF(TB_HALF),
    .TB_DONE(TB_DONE), .TB_DATA(TB_DATA), .ACK_PULSE(ACK_PULSE), .DLY_DONE(DLY_DONE));

// ===== verilog/bdx_defs.vh
`ifndef BDX_DEFS_VH
`define BDX_DEFS_VH
// command codes
`define BDX_CMD_NOP 8'h00
`define BDX_CMD_GO 8'h08
`define BDX_CMD_GO_UNTIL 8'h0c
`define BDX_CMD_TRACE 8'h07
`define BDX_CMD_RDMEM_B 8'h30
`define BDX_CMD_RDMEM_BS 8'h31
`define BDX_CMD_RDMEM_W 8'h34
`define BDX_CMD_RDMEM_WS 8'h35
`define BDX_CMD_RDMEM_L 8'h38
`define BDX_CMD_RDMEM_LS 8'h39
`define BDX_CMD_RDREG_BASE 8'h60
`define BDX_CMD_RDREG_MASK 8'hf0
// register map, byte addresses
`define BDX_REG_CTRL 4'h0
`define BDX_REG_STAT 4'h4
`define BDX_REG_CMD 4'h8
`define BDX_REG_ADDR 4'hc
`define BDX_REG_RDATA 5'h10
`define BDX_REG_RDATA2 5'h14
`define BDX_REG_IRQ 5'h18
`define BDX_REG_MASK 5'h1c
// ctrl bits
`define BDX_CTRL_ACKEN 0
`define BDX_CTRL_SYNC 1
// irq bits
`define BDX_IRQ_DONE 0
`define BDX_IRQ_ILL 1
`define BDX_IRQ_HALT 2
`define BDX_IRQ_W 3
// status low byte layout
`define BDX_ST_HALTED 6
`define BDX_ST_ACKEN 5
`define BDX_ST_ILL 4
`define BDX_ST_BUSY 3
// timing: fixed delay slot and response timeout
`define BDX_DLY_CYCLES 16
`define BDX_TIMEOUT_CYCLES 512
`endif

// ===== verilog/bdx_exec.v
`timescale 1ns/1ps
`include "bdx_defs.vh"
module bdx_exec #(
    parameter REG_W = 32,
    parameter TIMEOUT = `BDX_TIMEOUT_CYCLES
) (
    input wire CLK_SYS,
    input wire RST,
    input wire [4:0] AVS_ADDRESS,
    input wire AVS_READ,
    input wire AVS_WRITE,
    input wire [31:0] AVS_WRITEDATA,
    output reg [31:0] AVS_READDATA,
    output wire AVS_WAITREQUEST,
    output wire IRQ,
    input wire CPU_HALTED,
    output reg CPU_RESUME,
    output reg CPU_FLUSH,
    output reg [3:0] REG_NUM,
    output reg REG_RD,
    input wire [REG_W-1:0] REG_DATA,
    output reg MEM_RD,
    output reg [23:0] MEM_ADDR,
    output reg [1:0] MEM_SIZE,
    input wire MEM_DONE,
    input wire [31:0] MEM_DATA,
    output reg TB_RD,
    output reg TB_HALF,
    input wire TB_DONE,
    input wire [31:0] TB_DATA,
    output reg ACK_PULSE,
    output reg DLY_DONE
);
    localparam S_IDLE = 3'd0;
    localparam S_MEM = 3'd1;
    localparam S_TB1 = 3'd2;
    localparam S_TBW = 3'd3;
    localparam S_TB2 = 3'd4;
    localparam S_GOU = 3'd5;
    localparam S_DLY = 3'd6;

    reg [2:0] st_ff;
    reg [7:0] cmd_ff;
    reg acken_ff;
    reg ill_ff;
    reg noresp_ff;
    reg [31:0] data_ff;
    reg [31:0] data2_ff;
    reg [3:0] irq_ff;
    reg [3:0] mask_ff;
    reg [9:0] cnt_ff;
    reg [4:0] dly_ff;
    reg halt_s1_ff;
    reg halt_s2_ff;
    reg halt_s3_ff;
    reg rd_ok_ff;

    wire [7:0] stat_lo;
    wire cmd_wr;
    wire busy;
    wire [7:0] wcmd;
    wire rdreg_cmd;
    wire ws;
    wire [3:0] ev;
    wire halt_entry;
    wire rd_take;
    wire [31:0] reg_data_ext;

    // halt comes from the cpu domain pins
    always @(posedge CLK_SYS) begin
        if (RST) begin
            halt_s1_ff <= 1'b0;
            halt_s2_ff <= 1'b0;
            // starts high, but with the first two stages reset low a cpu already halted out of reset still shows as an entry
            halt_s3_ff <= 1'b1;
        end else begin
            halt_s1_ff <= CPU_HALTED;
            halt_s2_ff <= halt_s1_ff;
            // only the entry detector reads this third stage
            halt_s3_ff <= halt_s2_ff;
        end
    end

    // one wait state per read, so registered read data stands when taken
    always @(posedge CLK_SYS) begin
        if (RST) begin
            rd_ok_ff <= 1'b0;
        end else begin
            rd_ok_ff <= rd_take;
        end
    end

    assign busy = (st_ff != S_IDLE);
    // status byte the with-status reads return
    assign stat_lo = {1'b0, halt_s2_ff, acken_ff, ill_ff, busy, noresp_ff, 2'b00};

    // reads see one wait state, writes none
    assign rd_take = AVS_READ && !rd_ok_ff;
    assign AVS_WAITREQUEST = rd_take;
    assign IRQ = |(irq_ff & mask_ff);
    assign cmd_wr = AVS_WRITE && (AVS_ADDRESS == `BDX_REG_CMD) && !busy;
    assign wcmd = AVS_WRITEDATA[7:0];
    assign rdreg_cmd = (wcmd & `BDX_CMD_RDREG_MASK) == `BDX_CMD_RDREG_BASE;
    assign ws = cmd_ff[0];
    assign halt_entry = halt_s2_ff & ~halt_s3_ff;
    assign ev = {1'b0, halt_entry, 2'b00};

    // narrow registers pad with zero bytes;
    // a full width one passes whole, with no zero-width replication
    generate
        if (REG_W < 32) begin : g_pad
            assign reg_data_ext = {{(32-REG_W){1'b0}}, REG_DATA};
        end else begin : g_full
            assign reg_data_ext = REG_DATA[31:0];
        end
    endgenerate

    always @(posedge CLK_SYS) begin
        if (RST) begin
            AVS_READDATA <= 32'h0000_0000;
        end else if (rd_take) begin
            if (AVS_ADDRESS == `BDX_REG_CTRL) begin
                AVS_READDATA <= {31'h0, acken_ff};
            end else if (AVS_ADDRESS == `BDX_REG_STAT) begin
                AVS_READDATA <= {24'h0, stat_lo};
            end else if (AVS_ADDRESS == `BDX_REG_CMD) begin
                AVS_READDATA <= {24'h0, cmd_ff};
            end else if (AVS_ADDRESS == `BDX_REG_ADDR) begin
                AVS_READDATA <= {8'h00, MEM_ADDR};
            end else if (AVS_ADDRESS == `BDX_REG_RDATA) begin
                AVS_READDATA <= data_ff;
            end else if (AVS_ADDRESS == `BDX_REG_RDATA2) begin
                AVS_READDATA <= data2_ff;
            end else if (AVS_ADDRESS == `BDX_REG_IRQ) begin
                AVS_READDATA <= {28'h0, irq_ff};
            end else if (AVS_ADDRESS == `BDX_REG_MASK) begin
                AVS_READDATA <= {28'h0, mask_ff};
            end else begin
                AVS_READDATA <= 32'h0000_0000;
            end
        end
    end

    always @(posedge CLK_SYS) begin
        if (RST) begin
            st_ff <= S_IDLE;
            cmd_ff <= 8'h00;
            acken_ff <= 1'b0;
            ill_ff <= 1'b0;
            noresp_ff <= 1'b0;
            data_ff <= 32'h0000_0000;
            data2_ff <= 32'h0000_0000;
            irq_ff <= 4'h0;
            mask_ff <= 4'h0;
            cnt_ff <= 10'h000;
            dly_ff <= 5'h00;
            CPU_RESUME <= 1'b0;
            CPU_FLUSH <= 1'b0;
            REG_NUM <= 4'h0;
            REG_RD <= 1'b0;
            MEM_RD <= 1'b0;
            MEM_ADDR <= 24'h000000;
            MEM_SIZE <= 2'b00;
            TB_RD <= 1'b0;
            TB_HALF <= 1'b0;
            ACK_PULSE <= 1'b0;
            DLY_DONE <= 1'b0;
        end else begin
            CPU_RESUME <= 1'b0;
            CPU_FLUSH <= 1'b0;
            REG_RD <= 1'b0;
            ACK_PULSE <= 1'b0;
            DLY_DONE <= 1'b0;

            // cleared in the cycle the read captures it; set wins over the clear
            if (rd_take && AVS_ADDRESS == `BDX_REG_IRQ) begin
                irq_ff <= ev;
            end else begin
                irq_ff <= irq_ff | ev;
            end

            if (AVS_WRITE && AVS_ADDRESS == `BDX_REG_MASK) begin
                mask_ff <= AVS_WRITEDATA[3:0];
            end

            if (AVS_WRITE && AVS_ADDRESS == `BDX_REG_CTRL) begin
                acken_ff <= AVS_WRITEDATA[`BDX_CTRL_ACKEN];
                // sync ends a pending resume-until-halt
                if (AVS_WRITEDATA[`BDX_CTRL_SYNC]) begin
                    st_ff <= S_IDLE;
                    MEM_RD <= 1'b0;
                    TB_RD <= 1'b0;
                end
            end

            if (cmd_wr) begin
                cmd_ff <= wcmd;
                if (wcmd == `BDX_CMD_NOP) begin
                    // filler, only records the command and raises the done interrupt bit
                    irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                end else if (wcmd == `BDX_CMD_GO || wcmd == `BDX_CMD_GO_UNTIL) begin
                    if (!halt_s2_ff) begin
                        ill_ff <= 1'b1;
                        irq_ff[`BDX_IRQ_ILL] <= 1'b1;
                    end else begin
                        // cpu refetches from its live pc, so edits stick
                        CPU_RESUME <= 1'b1;
                        CPU_FLUSH <= 1'b1;
                        if (wcmd == `BDX_CMD_GO_UNTIL && acken_ff) begin
                            st_ff <= S_GOU;
                        end else begin
                            ACK_PULSE <= acken_ff;
                            irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                        end
                    end
                end else if (rdreg_cmd) begin
                    if (!halt_s2_ff) begin
                        ill_ff <= 1'b1;
                        irq_ff[`BDX_IRQ_ILL] <= 1'b1;
                    end else begin
                        REG_NUM <= wcmd[3:0];
                        REG_RD <= 1'b1;
                        data_ff <= reg_data_ext;
                        ACK_PULSE <= acken_ff;
                        irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                    end
                end else if (wcmd[7:4] == 4'h3 && wcmd[1] == 1'b0 && wcmd[3:2] != 2'b11) begin
                    MEM_SIZE <= wcmd[3:2];
                    MEM_ADDR <= (wcmd[3:2] == 2'b10) ?
                        {AVS_WRITEDATA[31:10], 2'b00} : AVS_WRITEDATA[31:8];
                    MEM_RD <= 1'b1;
                    cnt_ff <= 10'h000;
                    st_ff <= S_MEM;
                end else if (wcmd == `BDX_CMD_TRACE) begin
                    TB_RD <= 1'b1;
                    TB_HALF <= 1'b0;
                    cnt_ff <= 10'h000;
                    st_ff <= S_TB1;
                end else begin
                    ill_ff <= 1'b1;
                    irq_ff[`BDX_IRQ_ILL] <= 1'b1;
                end
            end else begin
                case (st_ff)
                    S_MEM: begin
                        cnt_ff <= cnt_ff + 10'h001;
                        if (MEM_DONE) begin
                            MEM_RD <= 1'b0;
                            // right-justified, msb first on the wire
                            data_ff <= MEM_DATA;
                            if (ws) begin
                                dly_ff <= 5'h00;
                                st_ff <= S_DLY;
                            end else begin
                                ACK_PULSE <= acken_ff;
                                irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                                st_ff <= S_IDLE;
                            end
                        end else if (cnt_ff == TIMEOUT[9:0]) begin
                            MEM_RD <= 1'b0;
                            noresp_ff <= 1'b1;
                            st_ff <= S_IDLE;
                        end
                    end
                    S_DLY: begin
                        dly_ff <= dly_ff + 5'h01;
                        if (dly_ff == `BDX_DLY_CYCLES - 1) begin
                            // status captured after access
                            data2_ff <= {24'h0, stat_lo};
                            DLY_DONE <= 1'b1;
                            irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                            st_ff <= S_IDLE;
                        end
                    end
                    S_TB1, S_TB2: begin
                        cnt_ff <= cnt_ff + 10'h001;
                        if (TB_DONE) begin
                            TB_RD <= 1'b0;
                            ACK_PULSE <= acken_ff;
                            if (st_ff == S_TB1) begin
                                data_ff <= TB_DATA;
                                dly_ff <= 5'h00;
                                st_ff <= S_TBW;
                            end else begin
                                data2_ff <= TB_DATA;
                                irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                                st_ff <= S_IDLE;
                            end
                        end else if (cnt_ff == TIMEOUT[9:0]) begin
                            // second half can still time out
                            TB_RD <= 1'b0;
                            noresp_ff <= 1'b1;
                            st_ff <= S_IDLE;
                        end
                    end
                    S_TBW: begin
                        // gap covers hosts running without acknowledge
                        dly_ff <= dly_ff + 5'h01;
                        if (dly_ff == `BDX_DLY_CYCLES - 1) begin
                            TB_RD <= 1'b1;
                            TB_HALF <= 1'b1;
                            cnt_ff <= 10'h000;
                            st_ff <= S_TB2;
                        end
                    end
                    S_GOU: begin
                        // no timeout here, waits for halt entry or a sync write
                        // entry edge, since the synced level lags the resume by three cycles
                        if (halt_entry) begin
                            ACK_PULSE <= acken_ff;
                            irq_ff[`BDX_IRQ_DONE] <= 1'b1;
                            st_ff <= S_IDLE;
                        end
                    end
                    default: begin
                        st_ff <= S_IDLE;
                    end
                endcase
            end
        end
    end
endmodule // bdx_exec
